//--- hdl/lcdcd_decoder.sv
// Command decoder and power-saver controller of the dot-matrix LCD driver.
`timescale 1ns/1ns
// Function
// - Byte after drive-mode command: bits 7:6 pick strength, lower six bits zero.
// - Drive strength resets to code 00, the first mode.
// - All-points-on while display off enters power saver.
// - Power saver goes to sleep if indicator off, standby if on.
// - Saver keeps RAM and settings; host RAM access still works.
// - Sleep stops oscillator and the liquid-crystal supply.
// - Sleep stops all drive; segment and common outputs at supply.
// - Standby stops liquid-crystal supply, oscillator keeps running.
// - Standby stops duty drive; only static indicator keeps running.
// - Internal reset command in standby moves to sleep.
// - Blanking output goes low when power saver begins.
// - Test command never used; cleared by hardware reset or NO_OPERATION_COMMAND.
// - Command 01xxxxxx loads the display start line.
// - Command 1011xxxx loads the page address.
// - Commands 0001 and 0000 load column high and low nibbles.
// - Status read gives flags in bits 7:4, zeros below.
// - Data writes store to RAM, data reads return RAM at page and column.
// - Segment direction bit 0: normal or reversed column mapping.
// - All-points bit 0: normal display or every dot on.
// - Bias bit 0: one ninth or one seventh.
// - Read-modify-write: column +1 on writes, held on reads; end clears.
// - Common mode bit 3 selects row scan direction.
// - After a pair's first byte the next command byte is its register byte; data bytes still go to RAM.
// - Byte following drive-mode command goes into drive-mode register.
module lcdcd_decoder (
    input  wire logic        clk,                  // System clock, 100 MHz.
    input  wire logic        reset_n,              // Synchronous reset, active low.
    input  wire logic        clk_en,               // Freezes all state while low.
    input  wire logic        enable_pulse,         // One-cycle host access strobe.
    input  wire logic        register_select,      // 0 command/status, 1 display data.
    input  wire logic        read_write_select,    // 1 read, 0 write.
    input  wire logic [7:0]  host_data_in,         // Host write byte.
    output logic             host_ready,           // Write buffer has room.
    output logic      [7:0]  host_data_out,        // Read answer byte.
    output logic             host_data_valid,      // Read answer strobe.
    output logic             blanking_out_n,       // Low while power saver active.
    output logic             osc_enable,           // Oscillator runs.
    output logic             lc_supply_enable,     // Liquid-crystal supply runs.
    output logic             duty_drive_enable,    // Multiplexed drive runs.
    output logic             static_drive_enable,  // Static indicator drive runs.
    output logic             outputs_at_supply,    // Segment and common held at supply.
    output logic             display_on,           // Display on/off setting.
    output logic             all_points_on,        // Force every dot on.
    output logic             inverse_display,      // Normal/reverse setting.
    output logic             column_reversed,      // Segment order reversed.
    output logic             row_reversed,         // Common scan reversed.
    output logic             bias_seventh,         // 1 selects one seventh bias.
    output logic      [1:0]  drive_strength,       // Drive-mode code, bits 7:6.
    output logic      [5:0]  start_line,           // First displayed RAM line.
    output logic      [5:0]  volume_level,         // Electronic volume value.
    output logic      [1:0]  indicator_mode,       // Static indicator blink mode.
    output logic             indicator_on,         // Static indicator enabled.
    output logic      [7:0]  blink_pages,          // Page blink mask.
    output logic      [2:0]  power_mode,           // Power control operating mode.
    output logic      [2:0]  resistor_ratio,       // Regulator resistor ratio.
    output logic             test_mode,            // Test mode accidentally entered.
    output logic      [1:0]  power_state           // 0 active, 1 sleep, 2 standby.
);
    logic [8:0]  fifo_data;
    logic        fifo_valid;
    logic        fifo_in_ready;
    logic        fifo_pop;
    logic        is_write;
    logic        is_read;
    logic [7:0]  byte_in;
    logic        byte_is_data;

    logic [7:0]  ram_ff [lcdcd_pkg::RAM_WORDS];
    logic [3:0]  page_ff;
    logic [7:0]  column_ff;
    logic        rmw_ff;
    logic        display_on_ff;
    logic        all_on_ff;
    logic        inverse_ff;
    logic        col_rev_ff;
    logic        row_rev_ff;
    logic        bias_ff;
    logic [1:0]  drive_ff;
    logic [5:0]  start_ff;
    logic [5:0]  volume_ff;
    logic [1:0]  ind_mode_ff;
    logic        ind_on_ff;
    logic [7:0]  blink_ff;
    logic [2:0]  pwr_mode_ff;
    logic [2:0]  ratio_ff;
    logic        test_ff;
    logic [7:0]  rd_data_ff;
    logic        rd_valid_ff;
    logic        host_ready_ff;
    lcdcd_pkg::lcdcd_cmd_type cmd_ff;
    lcdcd_pkg::lcdcd_pwr_type pwr_ff;
    lcdcd_pkg::lcdcd_pwr_type nxt_pwr;
    logic        cmd_take;
    logic        soft_reset;
    logic [lcdcd_pkg::RAM_AW-1:0] ram_addr;
    logic        addr_ok;

    // Reads bypass the FIFO; the host lets writes drain first.
    assign is_write = enable_pulse && !read_write_select;
    assign is_read  = enable_pulse && read_write_select;

    lcdcd_fifo #(
        .WIDTH (9),
        .DEPTH (lcdcd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .clk_en    (clk_en),
        .in_data   ({register_select, host_data_in}),
        .in_valid  (is_write),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (1'b1)
    );

    assign fifo_pop     = fifo_valid;
    assign byte_is_data = fifo_data[8];
    assign byte_in      = fifo_data[7:0];
    assign cmd_take     = fifo_pop && !byte_is_data;
    assign ram_addr     = lcdcd_pkg::RAM_AW'(page_ff * lcdcd_pkg::RAM_COLS + column_ff);
    assign addr_ok      = (page_ff < 4'(lcdcd_pkg::RAM_PAGES)) && (column_ff < 8'(lcdcd_pkg::RAM_COLS));
    assign soft_reset   = cmd_take && (cmd_ff == lcdcd_pkg::LCDCD_CMD_NORMAL)
                          && (byte_in == lcdcd_pkg::CMD_RESET);

    // Ready is pessimistic by one so a write in flight never overflows.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            host_ready_ff <= 1'b0;
        end else if (clk_en) begin
            host_ready_ff <= fifo_in_ready && !is_write;
        end
    end

    // Command decoding and pair sequencing.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cmd_ff      <= lcdcd_pkg::LCDCD_CMD_NORMAL;
            display_on_ff <= 1'b0;
            all_on_ff   <= 1'b0;
            inverse_ff  <= 1'b0;
            col_rev_ff  <= 1'b0;
            row_rev_ff  <= 1'b0;
            bias_ff     <= 1'b0;
            drive_ff    <= lcdcd_pkg::DRIVE_RESET;
            start_ff    <= '0;
            volume_ff   <= '0;
            ind_mode_ff <= '0;
            ind_on_ff   <= 1'b0;
            blink_ff    <= '0;
            pwr_mode_ff <= '0;
            ratio_ff    <= '0;
            test_ff     <= 1'b0;
            rmw_ff      <= 1'b0;
        end else if (clk_en && cmd_take) begin
            case (cmd_ff)
                lcdcd_pkg::LCDCD_CMD_VOLUME: begin
                    volume_ff <= byte_in[5:0];
                    cmd_ff    <= lcdcd_pkg::LCDCD_CMD_NORMAL;
                end
                lcdcd_pkg::LCDCD_CMD_INDICATOR: begin
                    ind_mode_ff <= byte_in[1:0];
                    cmd_ff      <= lcdcd_pkg::LCDCD_CMD_NORMAL;
                end
                lcdcd_pkg::LCDCD_CMD_BLINK: begin
                    blink_ff <= byte_in;
                    cmd_ff   <= lcdcd_pkg::LCDCD_CMD_NORMAL;
                end
                lcdcd_pkg::LCDCD_CMD_DRIVE: begin
                    drive_ff <= {byte_in[lcdcd_pkg::DRIVE_HI_BIT], byte_in[lcdcd_pkg::DRIVE_LO_BIT]};
                    cmd_ff   <= lcdcd_pkg::LCDCD_CMD_NORMAL;
                end
                default: begin
                    if (byte_in[7:6] == lcdcd_pkg::TOP_START_LINE) begin
                        start_ff <= byte_in[5:0];
                    end else if (byte_in[7:4] == lcdcd_pkg::NIB_TEST) begin
                        test_ff <= 1'b1;
                    end else if (byte_in[7:4] == lcdcd_pkg::NIB_COM_DIR) begin
                        row_rev_ff <= byte_in[lcdcd_pkg::COM_DIR_BIT];
                    end else if (byte_in[7:3] == lcdcd_pkg::TOP_POWER_CTRL) begin
                        pwr_mode_ff <= byte_in[2:0];
                    end else if (byte_in[7:3] == lcdcd_pkg::TOP_RES_RATIO) begin
                        ratio_ff <= byte_in[2:0];
                    end else begin
                        case (byte_in[7:1])
                            lcdcd_pkg::CMD_DISP_OFF[7:1]: display_on_ff <= byte_in[0];
                            lcdcd_pkg::CMD_SEG_DIR[7:1]:  col_rev_ff    <= byte_in[0];
                            lcdcd_pkg::CMD_INVERSE[7:1]:  inverse_ff    <= byte_in[0];
                            lcdcd_pkg::CMD_ALL_ON[7:1]:   all_on_ff     <= byte_in[0];
                            lcdcd_pkg::CMD_BIAS[7:1]:     bias_ff       <= byte_in[0];
                            default: begin
                                case (byte_in)
                                    lcdcd_pkg::CMD_RMW:        rmw_ff <= 1'b1;
                                    lcdcd_pkg::CMD_END:        rmw_ff <= 1'b0;
                                    lcdcd_pkg::CMD_NOP:        test_ff <= 1'b0;
                                    lcdcd_pkg::CMD_VOL_MODE:   cmd_ff <= lcdcd_pkg::LCDCD_CMD_VOLUME;
                                    lcdcd_pkg::CMD_IND_OFF:    ind_on_ff <= 1'b0;
                                    lcdcd_pkg::CMD_IND_ON: begin
                                        ind_on_ff <= 1'b1;
                                        cmd_ff    <= lcdcd_pkg::LCDCD_CMD_INDICATOR;
                                    end
                                    lcdcd_pkg::CMD_BLINK_MODE: cmd_ff <= lcdcd_pkg::LCDCD_CMD_BLINK;
                                    lcdcd_pkg::CMD_DRIVE_MODE: cmd_ff <= lcdcd_pkg::LCDCD_CMD_DRIVE;
                                    lcdcd_pkg::CMD_RESET: begin
                                        // Internal reset re-inits addressing and modes but not RAM.
                                        start_ff   <= '0;
                                        rmw_ff     <= 1'b0;
                                        volume_ff  <= '0;
                                        pwr_mode_ff <= '0;
                                        ratio_ff   <= '0;
                                    end
                                    default: ;
                                endcase
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    // Page and column pointers.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            page_ff   <= '0;
            column_ff <= '0;
        end else if (clk_en) begin
            if (cmd_take && cmd_ff == lcdcd_pkg::LCDCD_CMD_NORMAL) begin
                if (byte_in[7:4] == lcdcd_pkg::NIB_PAGE) begin
                    page_ff <= byte_in[3:0];
                end else if (byte_in[7:4] == lcdcd_pkg::NIB_COL_HI) begin
                    column_ff[7:4] <= byte_in[3:0];
                end else if (byte_in[7:4] == lcdcd_pkg::NIB_COL_LO) begin
                    column_ff[3:0] <= byte_in[3:0];
                end else if (soft_reset) begin
                    column_ff <= '0;
                    page_ff   <= '0;
                end
            end else if (fifo_pop && byte_is_data) begin
                column_ff <= column_ff + 1'b1;
            end else if (is_read && register_select && !fifo_valid && !rmw_ff) begin
                column_ff <= column_ff + 1'b1;
            end
        end
    end

    // Display RAM stays writable in every power state.
    always_ff @(posedge clk) begin
        if (clk_en && fifo_pop && byte_is_data && addr_ok) begin
            ram_ff[ram_addr] <= byte_in;
        end
    end

    // Read answers: status or RAM byte.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_data_ff  <= '0;
            rd_valid_ff <= 1'b0;
        end else if (clk_en) begin
            rd_valid_ff <= is_read;
            if (is_read && !register_select) begin
                rd_data_ff <= {fifo_valid, col_rev_ff, !display_on_ff, !reset_n, 4'h0_0};
            end else if (is_read) begin
                rd_data_ff <= addr_ok ? ram_ff[ram_addr] : 8'h00_00;
            end
        end
    end

    // Power-saver state machine.
    always_comb begin
        nxt_pwr = pwr_ff;
        case (pwr_ff)
            lcdcd_pkg::LCDCD_PWR_ACTIVE: begin
                if (all_on_ff && !display_on_ff) begin
                    nxt_pwr = ind_on_ff ? lcdcd_pkg::LCDCD_PWR_STANDBY : lcdcd_pkg::LCDCD_PWR_SLEEP;
                end
            end
            lcdcd_pkg::LCDCD_PWR_STANDBY: begin
                if (soft_reset) begin
                    nxt_pwr = lcdcd_pkg::LCDCD_PWR_SLEEP;
                end else if (!all_on_ff || display_on_ff) begin
                    nxt_pwr = lcdcd_pkg::LCDCD_PWR_ACTIVE;
                end
            end
            lcdcd_pkg::LCDCD_PWR_SLEEP: begin
                if (!all_on_ff || display_on_ff) begin
                    nxt_pwr = lcdcd_pkg::LCDCD_PWR_ACTIVE;
                end
            end
            default: nxt_pwr = lcdcd_pkg::LCDCD_PWR_ACTIVE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pwr_ff <= lcdcd_pkg::LCDCD_PWR_ACTIVE;
        end else if (clk_en) begin
            pwr_ff <= nxt_pwr;
        end
    end

    // Power and drive outputs.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            blanking_out_n      <= 1'b1;
            osc_enable          <= 1'b1;
            lc_supply_enable    <= 1'b1;
            duty_drive_enable   <= 1'b0;
            static_drive_enable <= 1'b0;
            outputs_at_supply   <= 1'b1;
            power_state         <= 2'h0_0;
        end else if (clk_en) begin
            blanking_out_n      <= (nxt_pwr == lcdcd_pkg::LCDCD_PWR_ACTIVE);
            osc_enable          <= (nxt_pwr != lcdcd_pkg::LCDCD_PWR_SLEEP);
            lc_supply_enable    <= (nxt_pwr == lcdcd_pkg::LCDCD_PWR_ACTIVE);
            duty_drive_enable   <= (nxt_pwr == lcdcd_pkg::LCDCD_PWR_ACTIVE) && display_on_ff;
            static_drive_enable <= (nxt_pwr != lcdcd_pkg::LCDCD_PWR_SLEEP) && ind_on_ff;
            outputs_at_supply   <= (nxt_pwr != lcdcd_pkg::LCDCD_PWR_ACTIVE) || !display_on_ff;
            power_state         <= 2'(nxt_pwr);
        end
    end

    // Settings mirrors.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            display_on      <= 1'b0;
            all_points_on   <= 1'b0;
            inverse_display <= 1'b0;
            column_reversed <= 1'b0;
            row_reversed    <= 1'b0;
            bias_seventh    <= 1'b0;
            drive_strength  <= lcdcd_pkg::DRIVE_RESET;
            start_line      <= '0;
            volume_level    <= '0;
            indicator_mode  <= '0;
            indicator_on    <= 1'b0;
            blink_pages     <= '0;
            power_mode      <= '0;
            resistor_ratio  <= '0;
            test_mode       <= 1'b0;
            host_data_out   <= '0;
            host_data_valid <= 1'b0;
            host_ready      <= 1'b0;
        end else if (clk_en) begin
            display_on      <= display_on_ff;
            all_points_on   <= all_on_ff;
            inverse_display <= inverse_ff;
            column_reversed <= col_rev_ff;
            row_reversed    <= row_rev_ff;
            bias_seventh    <= bias_ff;
            drive_strength  <= drive_ff;
            start_line      <= start_ff;
            volume_level    <= volume_ff;
            indicator_mode  <= ind_mode_ff;
            indicator_on    <= ind_on_ff;
            blink_pages     <= blink_ff;
            power_mode      <= pwr_mode_ff;
            resistor_ratio  <= ratio_ff;
            test_mode       <= test_ff;
            host_data_out   <= rd_data_ff;
            host_data_valid <= rd_valid_ff;
            host_ready      <= host_ready_ff;
        end
    end
endmodule

//--- common/lcdcd_pkg.sv
// Package with command codes, field positions, reset values and sizes for the LCD command decoder.
package lcdcd_pkg;
    localparam int COL_W       = 8;
    localparam int PAGE_W      = 4;
    localparam int LINE_W      = 6;
    localparam int DATA_W      = 8;
    localparam int FIFO_DEPTH  = 32;
    localparam int RAM_PAGES   = 9;
    localparam int RAM_COLS    = 132;
    localparam int RAM_WORDS   = RAM_PAGES * RAM_COLS;
    localparam int RAM_AW      = 11;
    localparam int SEG_W       = 132;
    localparam int COM_W       = 65;

    localparam logic [7:0] CMD_DISP_OFF    = 8'h00_AE;
    localparam logic [7:0] CMD_DISP_ON     = 8'h00_AF;
    localparam logic [7:0] CMD_SEG_DIR     = 8'h00_A0;
    localparam logic [7:0] CMD_INVERSE     = 8'h00_A6;
    localparam logic [7:0] CMD_ALL_ON      = 8'h00_A4;
    localparam logic [7:0] CMD_BIAS        = 8'h00_A2;
    localparam logic [7:0] CMD_RMW         = 8'h00_E0;
    localparam logic [7:0] CMD_END         = 8'h00_EE;
    localparam logic [7:0] CMD_RESET       = 8'h00_E2;
    localparam logic [7:0] CMD_NOP         = 8'h00_E3;
    localparam logic [7:0] CMD_VOL_MODE    = 8'h00_81;
    localparam logic [7:0] CMD_IND_OFF     = 8'h00_AC;
    localparam logic [7:0] CMD_IND_ON      = 8'h00_AD;
    localparam logic [7:0] CMD_BLINK_MODE  = 8'h00_D5;
    localparam logic [7:0] CMD_DRIVE_MODE  = 8'h00_D2;
    localparam logic [3:0] NIB_PAGE        = 4'h0_B;
    localparam logic [3:0] NIB_COL_HI      = 4'h0_1;
    localparam logic [3:0] NIB_COL_LO      = 4'h0_0;
    localparam logic [3:0] NIB_TEST        = 4'h0_F;
    localparam logic [3:0] NIB_COM_DIR     = 4'h0_C;
    localparam logic [1:0] TOP_START_LINE  = 2'h0_1;
    localparam logic [4:0] TOP_POWER_CTRL  = 5'h0_5;
    localparam logic [4:0] TOP_RES_RATIO   = 5'h0_4;

    localparam logic [1:0] DRIVE_RESET     = 2'h0_0;
    localparam int         DRIVE_HI_BIT    = 7;
    localparam int         DRIVE_LO_BIT    = 6;
    localparam int         COM_DIR_BIT     = 3;

    typedef enum logic [2:0] {
        LCDCD_CMD_NORMAL,
        LCDCD_CMD_VOLUME,
        LCDCD_CMD_INDICATOR,
        LCDCD_CMD_BLINK,
        LCDCD_CMD_DRIVE
    } lcdcd_cmd_type;

    typedef enum logic [1:0] {
        LCDCD_PWR_ACTIVE,
        LCDCD_PWR_SLEEP,
        LCDCD_PWR_STANDBY
    } lcdcd_pwr_type;
endpackage

//--- hdl/lcdcd_fifo.sv
// Synchronous FIFO buffering host bytes ahead of the command decoder.
`timescale 1ns/1ns
module lcdcd_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,      // System clock.
    input  wire logic             reset_n,  // Synchronous reset, active low.
    input  wire logic             clk_en,   // Freezes state while low.
    input  wire logic [WIDTH-1:0] in_data,  // Write data.
    input  wire logic             in_valid, // Write request.
    output logic                  in_ready, // Space available.
    output logic      [WIDTH-1:0] out_data, // Head data.
    output logic                  out_valid,// Head valid.
    input  wire logic             out_ready // Consumer takes head.
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             push;
    logic             pop;

    assign in_ready  = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (clk_en && push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule

//--- testbench/lcdcd_decoder_monitor.sv
// Checker of power-saver and read behaviour.
`timescale 1ns/1ns
module lcdcd_decoder_monitor (
    input wire logic       clk,               // Clock.
    input wire logic       reset_n,           // Reset.
    input wire logic       enable_pulse,      // Strobe.
    input wire logic       register_select,   // Data.
    input wire logic       read_write_select, // Read.
    input wire logic [7:0] host_data_in,      // Byte.
    input wire logic       host_data_valid,   // Answer.
    input wire logic [7:0] host_data_out,     // Answer.
    input wire logic       blanking_out_n,    // Blank.
    input wire logic       osc_enable,        // Osc.
    input wire logic       lc_supply_enable,  // Supply.
    input wire logic       outputs_at_supply, // Parked.
    input wire logic [1:0] drive_strength,    // Drive.
    input wire logic       test_mode,         // Test.
    input wire logic [1:0] power_state        // Power.
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire cmd_wr = enable_pulse && !read_write_select && !register_select;
    drive_reset_a: assert property ($rose(reset_n) |-> drive_strength == 2'h0_0) else $error("drive not reset");
    sleep_state_a: assert property (power_state == 2'h0_1 [*2] |->
        !osc_enable && !lc_supply_enable && outputs_at_supply) else $error("sleep outputs wrong");
    standby_state_a: assert property (power_state == 2'h0_2 [*2] |->
        osc_enable && !lc_supply_enable && outputs_at_supply) else $error("standby outputs wrong");
    saver_blank_a: assert property (power_state != 2'h0_0 [*2] |-> !blanking_out_n) else $error("not blanked");
    read_answer_a: assert property (enable_pulse && read_write_select |-> ##2 host_data_valid) else $error("no answer");
    status_low_a: assert property (enable_pulse && read_write_select && !register_select ##2 host_data_valid
        |-> host_data_out[3:0] == 4'h0_0) else $error("status low bits set");
    reset_to_sleep_a: assert property (power_state == 2'h0_2 && cmd_wr && host_data_in == 8'h00_E2
        |-> ##[1:6] power_state == 2'h0_1) else $error("standby kept");
    nop_clears_a: assert property (cmd_wr && host_data_in == 8'h00_E3 |-> ##[1:5] !test_mode) else $error("test kept");
endmodule
bind lcdcd_decoder lcdcd_decoder_monitor lcdcd_decoder_monitor_i (.*);

//--- testbench/lcdcd_host.sv
// Host processor model on the parallel access strobe.
`timescale 1ns/1ns
module lcdcd_host (
    input wire logic       clk,                        // Clock.
    input wire logic       host_ready,                 // Room.
    input wire logic       host_data_valid,            // Answer.
    input wire logic [7:0] host_data_out,              // Answer.
    output logic           enable_pulse = 1'b0,        // Strobe.
    output logic           register_select = 1'b0,     // Data.
    output logic           read_write_select = 1'b0,   // Read.
    output logic     [7:0] host_data_in = 8'h00        // Byte.
);
    // Each write waits for the mirrored settings to show.
    task put(input logic rs, input logic [7:0] d);
        @(posedge clk);
        while (!host_ready) @(posedge clk);
        enable_pulse <= 1'b1;
        register_select <= rs;
        read_write_select <= 1'b0;
        host_data_in <= d;
        @(posedge clk);
        enable_pulse <= 1'b0;
        host_data_in <= ~d;
        repeat (4) @(posedge clk);
    endtask
    task get(input logic rs, output logic [7:0] d);
        d = 8'hxx;
        @(posedge clk);
        enable_pulse <= 1'b1;
        register_select <= rs;
        read_write_select <= 1'b1;
        @(posedge clk);
        enable_pulse <= 1'b0;
        repeat (4) begin
            @(posedge clk);
            if (host_data_valid) d = host_data_out;
        end
    endtask
endmodule

//--- testbench/lcd_driver_command_decoder_test.sv
// Self-checking bench of the command decoder.
`timescale 1ns/1ns
module lcd_driver_command_decoder_test;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic enable_pulse, register_select, read_write_select, host_ready, host_data_valid, blanking_out_n, test_mode;
    logic [7:0] host_data_in, host_data_out, rd;
    logic [1:0] drive_strength, power_state;
    logic [5:0] start_line;
    logic bias_seventh, row_reversed;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    lcdcd_decoder lcdcd_decoder_i (.clk, .reset_n, .clk_en(1'b1), .enable_pulse, .register_select, .read_write_select,
        .host_data_in, .host_ready, .host_data_out, .host_data_valid, .blanking_out_n, .osc_enable(),
        .lc_supply_enable(), .duty_drive_enable(), .static_drive_enable(), .outputs_at_supply(), .display_on(),
        .all_points_on(), .inverse_display(), .column_reversed(), .row_reversed, .bias_seventh, .drive_strength,
        .start_line, .volume_level(), .indicator_mode(), .indicator_on(), .blink_pages(), .power_mode(),
        .resistor_ratio(), .test_mode, .power_state);
    lcdcd_host lcdcd_host_i (.clk, .host_ready, .host_data_valid, .host_data_out,
        .enable_pulse, .register_select, .read_write_select, .host_data_in);
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task cmd(input logic [7:0] d);
        lcdcd_host_i.put(1'b0, d);
    endtask
    task at;
        cmd(8'h00_B2);
        cmd(8'h00_13);
        cmd(8'h00_04);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk("drive", 8'h00_00, 8'(drive_strength));
        for (int i = 0; i < 4; i++) begin
            cmd(lcdcd_pkg::CMD_DRIVE_MODE);
            cmd({2'(i), 6'h0_0});
            chk("drive", 8'(i), 8'(drive_strength));
        end
        cmd(8'h00_65);
        chk("line", 8'h00_25, 8'(start_line));
        at();
        lcdcd_host_i.put(1'b1, 8'h00_5A);
        at();
        lcdcd_host_i.get(1'b1, rd);
        chk("ram", 8'h00_5A, rd);
        cmd(8'h00_A1);
        lcdcd_host_i.get(1'b0, rd);
        chk("status", 8'h00_60, rd);
        cmd(8'h00_A5);
        chk("power", 8'h00_01, 8'(power_state));
        chk("blank", 8'h00_00, 8'(blanking_out_n));
        at();
        lcdcd_host_i.get(1'b1, rd);
        chk("saved ram", 8'h00_5A, rd);
        cmd(8'h00_A4);
        chk("power", 8'h00_00, 8'(power_state));
        chk("blank", 8'h00_01, 8'(blanking_out_n));
        cmd(lcdcd_pkg::CMD_IND_ON);
        cmd(8'h00_03);
        cmd(8'h00_A5);
        chk("power", 8'h00_02, 8'(power_state));
        cmd(lcdcd_pkg::CMD_RESET);
        chk("power", 8'h00_01, 8'(power_state));
        cmd(8'h00_A4);
        cmd(8'h00_F0);
        chk("test", 8'h00_01, 8'(test_mode));
        cmd(lcdcd_pkg::CMD_NOP);
        chk("test", 8'h00_00, 8'(test_mode));
        chk("drive", 8'h00_03, 8'(drive_strength));
        cmd(8'h00_A3);
        cmd(8'h00_C8);
        chk("bias row", 8'h00_03, {6'h0_0, bias_seventh, row_reversed});
        end_of_test();
    end
endmodule
